// ==== bench/spcp_host.sv ====
// Host processor model driving the parallel port pins
`timescale 1ns/1ps
module spcp_host (
   // Clock
   input wire logic clock,
   // Host pins
   output logic reset_pin_n,
   output logic chip_sel_n,
   output logic bus_style_sel,
   output logic strobe_n,
   output logic dir_n,
   output logic [4:0] addr,
   output logic [7:0] data
);
   logic [7:0] exp_q[$];
   initial begin
      reset_pin_n = 1'b0;
      chip_sel_n = 1'b1;
      bus_style_sel = 1'b1;
      strobe_n = 1'b1;
      dir_n = 1'b1;
      addr = 5'h00;
      data = 8'hA5;
   end
   // One access: pins set after a falling edge, held five cycles, then released
   task automatic access(input logic st, input logic wr, input logic cs, input logic [4:0] a, input logic [7:0] d);
      @(negedge clock);
      bus_style_sel = st;
      chip_sel_n = cs;
      addr = a;
      data = wr ? d : ~data;
      strobe_n = st ? wr : 1'b0;
      dir_n = !wr;
      if (!wr && !cs) exp_q.push_back(d);
      repeat (5) @(negedge clock);
      strobe_n = 1'b1;
      dir_n = 1'b1;
      @(negedge clock);
      chip_sel_n = 1'b1;
      data = ~d;
      repeat (4) @(negedge clock);
   endtask
   task automatic pin_reset();
      @(negedge clock);
      reset_pin_n = 1'b0;
      repeat (spcp_pkg::RESET_MIN_CYC + 2) @(negedge clock);
      reset_pin_n = 1'b1;
   endtask
endmodule

// ==== bench/strobe_parallel_cpu_port_tb.sv ====
// Self-checking bench for the strobe parallel host port
`timescale 1ns/1ps
module strobe_parallel_cpu_port_tb;
   logic clock, rst, irq_event, reset_pin_n, chip_sel_n, bus_style_sel, strobe_n, dir_n;
   logic oe_n, oe_q, irq_out, irq_oe_n, dev_reset;
   logic [4:0] addr;
   logic [7:0] hdata, din, dout, shadow[32];
   logic [31:0] rng;
   int err_count, n_tests, i;
   // Data pins: device level while it drives, else the host's pattern
   assign din = !oe_n ? dout : hdata;
   spcp_host spcp_host_i (.clock(clock), .reset_pin_n(reset_pin_n), .chip_sel_n(chip_sel_n),
      .bus_style_sel(bus_style_sel), .strobe_n(strobe_n), .dir_n(dir_n), .addr(addr), .data(hdata));
   spcp_port spcp_port_i (.clock(clock), .rst(rst), .clk_en(1'b1), .reset_pin_n(reset_pin_n),
      .chip_sel_n(chip_sel_n), .bus_style_sel(bus_style_sel), .shared_access_strobe_n(strobe_n),
      .dir_write_strobe_n(dir_n), .host_addr(addr), .host_data_in(din), .host_data_out(dout),
      .host_data_oe_n(oe_n), .irq_event(irq_event), .irq_out(irq_out), .irq_oe_n(irq_oe_n), .dev_reset(dev_reset));
   function automatic logic [7:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction
   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic results();
      if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_irq(input logic lvl);
      for (i = 0; i < 12 && irq_oe_n !== lvl; i++) @(negedge clock);
      check("irq_oe_n", {7'h00, lvl}, {7'h00, irq_oe_n});
      check("irq_out", 8'h00, {7'h00, irq_out});
      if (irq_oe_n !== lvl) results();
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Every drive start takes the oldest expected read value
   always @(negedge clock) begin
      oe_q <= oe_n;
      if (oe_q === 1'b1 && oe_n === 1'b0) begin
         if (spcp_host_i.exp_q.size() == 0) check("drive while unselected", 8'h01, 8'h00);
         else check("read data", spcp_host_i.exp_q.pop_front(), dout);
      end
   end
   initial begin
      #200000;
      err_count++;
      results();
   end
   initial begin
      rst = 1'b1;
      irq_event = 1'b0;
      rng = 32'd85;
      err_count = 0;
      n_tests = 0;
      repeat (5) @(negedge clock);
      rst = 1'b0;
      fork
         spcp_host_i.pin_reset();
         begin
            repeat (40) @(negedge clock);
            check("dev_reset held", 8'h01, {7'h00, dev_reset});
            check("idle enable", 8'h01, {7'h00, oe_n});
         end
      join
      for (i = 0; i < 10 && dev_reset !== 1'b0; i++) @(negedge clock);
      check("dev_reset release", 8'h00, {7'h00, dev_reset});
      if (dev_reset !== 1'b0) results();
      for (int a = 0; a < 32; a++) spcp_host_i.access(a[0], 1'b0, 1'b0, a[4:0], 8'h00);
      for (int a = 1; a < 31; a++) begin
         shadow[a] = xs();
         spcp_host_i.access(a[1], 1'b1, 1'b0, a[4:0], shadow[a]);
      end
      for (int a = 1; a < 31; a++) spcp_host_i.access(!a[1], 1'b0, 1'b0, a[4:0], shadow[a]);
      for (int s = 0; s < 2; s++) begin
         spcp_host_i.access(s[0], 1'b1, 1'b1, 5'h05, ~shadow[5]);
         spcp_host_i.access(s[0], 1'b0, 1'b1, 5'h05, 8'h00);
      end
      check("drive released", 8'h01, {7'h00, oe_n});
      spcp_host_i.access(1'b0, 1'b0, 1'b0, 5'h05, shadow[5]);
      spcp_host_i.access(1'b1, 1'b1, 1'b0, spcp_pkg::PAGE_SEL_OFFSET, 8'h02);
      spcp_host_i.access(1'b0, 1'b0, 1'b0, spcp_pkg::PAGE_SEL_OFFSET, 8'h02);
      spcp_host_i.access(1'b1, 1'b0, 1'b0, 5'h05, spcp_pkg::REG_RESET_VAL);
      spcp_host_i.access(1'b0, 1'b1, 1'b0, 5'h05, 8'h3C);
      spcp_host_i.access(1'b1, 1'b0, 1'b0, 5'h05, 8'h3C);
      spcp_host_i.access(1'b0, 1'b1, 1'b0, spcp_pkg::PAGE_SEL_OFFSET, 8'h00);
      spcp_host_i.access(1'b1, 1'b0, 1'b0, 5'h05, shadow[5]);
      @(negedge clock);
      irq_event = 1'b1;
      @(negedge clock);
      irq_event = 1'b0;
      wait_irq(1'b0);
      repeat (20) @(negedge clock);
      wait_irq(1'b0);
      spcp_host_i.access(1'b0, 1'b1, 1'b0, 5'h00, 8'h01);
      wait_irq(1'b1);
      spcp_host_i.access(1'b1, 1'b0, 1'b0, 5'h00, 8'h01);
      fork
         spcp_host_i.pin_reset();
         begin
            repeat (40) @(negedge clock);
            check("dev_reset mid-run", 8'h01, {7'h00, dev_reset});
         end
      join
      repeat (6) @(negedge clock);
      check("dev_reset mid-run release", 8'h00, {7'h00, dev_reset});
      spcp_host_i.access(1'b0, 1'b0, 1'b0, 5'h05, spcp_pkg::REG_RESET_VAL);
      repeat (6) @(negedge clock);
      check("pending reads", 8'h00, 8'(spcp_host_i.exp_q.size()));
      results();
   end
endmodule

// ==== common/spcp_pkg.sv ====
// Constants for the strobe parallel host port
package spcp_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   localparam int PAGE_W = 3;
   // Register holding the current page number, mirrored in every page
   localparam logic [4:0] PAGE_SEL_OFFSET = 5'h1F;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   localparam logic [2:0] PAGE_RESET_VAL = 3'h0;
   // Bit of register 0 in page 0 that clears a pending interrupt request when written with 1
   localparam int IRQ_BIT = 0;
   // Reset pin minimum low time in ns and the cycle count at 125 MHz
   localparam int CLK_PERIOD_NS = 8;
   localparam int RESET_MIN_NS = 1000;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   typedef enum logic [1:0] {
      SPCP_IDLE,
      SPCP_READ,
      SPCP_WRITE
   } spcp_state_e;
endpackage

// ==== rtl/spcp_port.sv ====
// Non-multiplexed 8-bit parallel host port with paged registers
`timescale 1ns/1ps
// Function
// - Port is enabled only while chip select is low.
// - Chip select high: port idle, all data pins high impedance.
// - Style pin high selects split strobes, low selects data strobe plus direction.
// - Data-strobe style: shared strobe is the active-low access qualifier.
// - Split style: shared strobe is read strobe; data driven while asserted.
// - Data-strobe style: direction high means read, device drives data.
// - Data-strobe style: direction low means write, device takes data.
// - Split style: direction input is the active-low write strobe.
// - Data bus is eight bits, bit 0 least significant.
// - Host gives a five-bit address, input 0 least significant.
// - Interrupt output pulled low while a request is pending.
// - Interrupt output is open drain, never driven high.
// - Interrupt output works whatever chip select does.
// - Device stays reset while reset input is low.
// - Registers are paged; the address picks a location in current page.
module spcp_port #(
   parameter int NUM_PAGES = 8
) (
   // Clock, enable and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic reset_pin_n,
   // Host bus pins
   input wire logic chip_sel_n,
   input wire logic bus_style_sel,
   input wire logic shared_access_strobe_n,
   input wire logic dir_write_strobe_n,
   input wire logic [spcp_pkg::ADDR_W-1:0] host_addr,
   input wire logic [spcp_pkg::DATA_W-1:0] host_data_in,
   output logic [spcp_pkg::DATA_W-1:0] host_data_out,
   output logic host_data_oe_n,
   // Interrupt pin
   input wire logic irq_event,
   output logic irq_out,
   output logic irq_oe_n,
   // Internal reset seen by the rest of the device
   output logic dev_reset
);
   // Page number is three bits wide, so no more than eight pages
   if (NUM_PAGES < 1 || NUM_PAGES > 8) begin : g_bad_pages
      $error("NUM_PAGES must be 1 to 8");
   end

   localparam int DW = spcp_pkg::DATA_W;
   localparam int AW = spcp_pkg::ADDR_W;
   localparam int NPIN = 5 + AW + DW;

   // Synchronised pins; strobes idle high
   logic [NPIN-1:0] pins_s;
   logic rstpin_s;
   spcp_sync #(.W(NPIN), .INIT({4'hF, 1'b1, {(AW+DW){1'b0}}})) u_sync_bus (
      .clock(clock),
      .rst(rst),
      .clk_en(clk_en),
      .d({chip_sel_n, shared_access_strobe_n, dir_write_strobe_n, 1'b1, bus_style_sel, host_addr, host_data_in}),
      .q(pins_s)
   );
   spcp_sync #(.W(1), .INIT(1'b0)) u_sync_rst (
      .clock(clock),
      .rst(rst),
      .clk_en(clk_en),
      .d(reset_pin_n),
      .q(rstpin_s)
   );

   wire cs_n_s = pins_s[NPIN-1];
   wire strb_n_s = pins_s[NPIN-2];
   wire dir_n_s = pins_s[NPIN-3];
   wire style_split = pins_s[AW+DW];
   wire [AW-1:0] addr_s = pins_s[AW+DW-1:DW];
   wire [DW-1:0] wdata_s = pins_s[DW-1:0];

   // Internal reset: pin low or block reset holds everything but the pin synchronisers reset
   wire int_rst = rst || !rstpin_s;

   // Decode of the access style
   wire sel = !cs_n_s;
   wire rd_act = sel && (style_split ? !strb_n_s : (!strb_n_s && dir_n_s));
   wire wr_act = sel && (style_split ? (!dir_n_s && strb_n_s) : (!strb_n_s && !dir_n_s));

   spcp_pkg::spcp_state_e state_q, state_d;
   logic [2:0] page_q;
   logic [DW-1:0] regs_q [NUM_PAGES*32];
   logic [AW-1:0] waddr_q;
   logic [DW-1:0] wdata_q;
   logic irq_pend_q;

   wire [7:0] rindex = {page_q, addr_s};
   wire [7:0] windex = {page_q, waddr_q};
   wire [DW-1:0] rdata = (addr_s == spcp_pkg::PAGE_SEL_OFFSET) ? {5'h00, page_q} :
                         (32'(rindex) < NUM_PAGES*32) ? regs_q[rindex] : 8'h00;
   wire wr_commit = (state_q == spcp_pkg::SPCP_WRITE) && !wr_act;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         spcp_pkg::SPCP_IDLE: begin
            if (rd_act) begin
               state_d = spcp_pkg::SPCP_READ;
            end else if (wr_act) begin
               state_d = spcp_pkg::SPCP_WRITE;
            end
         end
         spcp_pkg::SPCP_READ: begin
            if (!rd_act) begin
               state_d = spcp_pkg::SPCP_IDLE;
            end
         end
         spcp_pkg::SPCP_WRITE: begin
            if (!wr_act) begin
               state_d = spcp_pkg::SPCP_IDLE;
            end
         end
         // Unused state code falls back to idle
         default: begin
            state_d = spcp_pkg::SPCP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (int_rst) begin
         state_q <= spcp_pkg::SPCP_IDLE;
         waddr_q <= '0;
         wdata_q <= '0;
      end else if (clk_en) begin
         state_q <= state_d;
         if (wr_act) begin
            waddr_q <= addr_s;
            wdata_q <= wdata_s;
         end
      end
   end

   // Write commits at strobe release, even if chip select rises with it
   always_ff @(posedge clock) begin
      if (int_rst) begin
         page_q <= spcp_pkg::PAGE_RESET_VAL;
         for (int i = 0; i < NUM_PAGES*32; i++) begin
            regs_q[i] <= spcp_pkg::REG_RESET_VAL;
         end
      end else if (clk_en && wr_commit) begin
         if (waddr_q == spcp_pkg::PAGE_SEL_OFFSET) begin
            page_q <= wdata_q[2:0];
         end else if (32'(windex) < NUM_PAGES*32) begin
            regs_q[windex] <= wdata_q;
         end
      end
   end

   // Data pins driven only during a selected read
   always_ff @(posedge clock) begin
      if (int_rst) begin
         host_data_oe_n <= 1'b1;
         host_data_out <= '0;
      end else if (clk_en) begin
         host_data_oe_n <= !rd_act;
         host_data_out <= rd_act ? rdata : '0;
      end
   end

   // Sticky interrupt: cleared by writing a 1 to bit IRQ_BIT of reg 0 in page 0; set wins
   wire irq_clr = wr_commit && windex == 8'h00 && wdata_q[spcp_pkg::IRQ_BIT];
   always_ff @(posedge clock) begin
      if (int_rst) begin
         irq_pend_q <= 1'b0;
         irq_oe_n <= 1'b1;
         irq_out <= 1'b0;
         dev_reset <= 1'b1;
      end else if (clk_en) begin
         irq_pend_q <= irq_event || (irq_pend_q && !irq_clr);
         irq_oe_n <= !irq_pend_q;
         irq_out <= 1'b0;
         dev_reset <= 1'b0;
      end
   end

   AST_NO_DRIVE_UNSELECTED: assert property (@(posedge clock) disable iff (int_rst)
      clk_en && cs_n_s |=> host_data_oe_n) else $error("data driven while deselected");
   AST_READ_DRIVES: assert property (@(posedge clock) disable iff (int_rst)
      clk_en && rd_act |=> !host_data_oe_n) else $error("read not driven");
   AST_IRQ_NEVER_HIGH: assert property (@(posedge clock) disable iff (int_rst)
      irq_out == 1'b0) else $error("irq driven high");
   AST_IRQ_FOLLOWS: assert property (@(posedge clock) disable iff (int_rst)
      clk_en && irq_event ##1 clk_en |=> !irq_oe_n) else $error("irq not asserted");
   AST_IRQ_NO_CS: assert property (@(posedge clock) disable iff (int_rst)
      clk_en && irq_event && cs_n_s ##1 clk_en |=> !irq_oe_n) else $error("irq depends on cs");
   AST_WRITE_LANDS: assert property (@(posedge clock) disable iff (int_rst)
      clk_en && wr_commit && waddr_q != spcp_pkg::PAGE_SEL_OFFSET && windex == 8'h01 |=>
      regs_q[1] == $past(wdata_q)) else $error("write lost");
   AST_PAGE_WRITE: assert property (@(posedge clock) disable iff (int_rst)
      clk_en && wr_commit && waddr_q == spcp_pkg::PAGE_SEL_OFFSET |=> page_q == $past(wdata_q[2:0]))
      else $error("page not switched");
   AST_IGNORE_DESEL: assert property (@(posedge clock) disable iff (int_rst)
      state_q == spcp_pkg::SPCP_IDLE && cs_n_s |=> state_q == spcp_pkg::SPCP_IDLE)
      else $error("access while deselected");
   AST_RESET_HOLDS: assert property (@(posedge clock)
      !rstpin_s |=> dev_reset && host_data_oe_n && irq_oe_n) else $error("reset not held");
   AST_STROBE_STYLE: assert property (@(posedge clock) disable iff (int_rst)
      !style_split && strb_n_s |-> !rd_act && !wr_act) else $error("access without strobe");

   COV_READ: cover property (@(posedge clock) state_q == spcp_pkg::SPCP_READ && style_split);
   COV_WRITE_DS: cover property (@(posedge clock) wr_commit && !style_split);
   COV_WRITE_SPLIT: cover property (@(posedge clock) wr_commit && style_split);
   AST_DS_READ_DIR: assert property (@(posedge clock) disable iff (int_rst)
      sel && !style_split && !strb_n_s && dir_n_s |-> rd_act && !wr_act) else $error("data-strobe read missed");
   AST_DS_WRITE_DIR: assert property (@(posedge clock) disable iff (int_rst)
      sel && !style_split && !strb_n_s && !dir_n_s |-> wr_act && !rd_act) else $error("data-strobe write missed");
   AST_SPLIT_WRITE: assert property (@(posedge clock) disable iff (int_rst)
      sel && style_split && strb_n_s && !dir_n_s |-> wr_act && !rd_act) else $error("split write missed");
   AST_READ_RELEASE: assert property (@(posedge clock) disable iff (int_rst)
      clk_en && state_q == spcp_pkg::SPCP_READ && !rd_act |=> host_data_oe_n) else $error("read drive held");
   AST_IRQ_RELEASE: assert property (@(posedge clock) disable iff (int_rst)
      clk_en && !irq_pend_q |=> irq_oe_n) else $error("irq held without request");
   AST_RESET_OUT: assert property (@(posedge clock)
      int_rst |=> dev_reset) else $error("device reset not shown");

   COV_IRQ: cover property (@(posedge clock) !irq_oe_n ##1 irq_clr);
   COV_PAGE_SWITCH: cover property (@(posedge clock) wr_commit && waddr_q == spcp_pkg::PAGE_SEL_OFFSET);
endmodule

// ==== rtl/spcp_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spcp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q <= INIT;
         q <= INIT;
      end else if (clk_en) begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
